// ==== rtl/sbr_regs.svh ====
// Constants of the receive sample bridge: widths, field positions,
// reset values and timing counts. Definitions only.
`ifndef SBR_REGS_SVH
`define SBR_REGS_SVH

// Sample word and packet widths
`define SBR_WORD_W 16
`define SBR_PKT_W 32
`define SBR_PKT_CNT_W 6

// Clock rates in kHz and the fractional bit clock step
`define SBR_MCLK_KHZ 10000
`define SBR_BIT_KHZ 1200
`define SBR_ACC_W 15
`define SBR_ACC_STEP (2 * `SBR_BIT_KHZ)

// Program line framing
`define SBR_PROG_W 16
`define SBR_PROG_FRAME 18
`define SBR_PROG_CNT_W 5
`define SBR_CLKSEL_BIT 0
`define SBR_CLKSEL_2M4 1'h1
`define SBR_PROG_BIT_NS 1600
`define SBR_PROG_BIT_CYC ((`SBR_PROG_BIT_NS * `SBR_MCLK_KHZ) / 1000000)
`define SBR_PROG_TMR_W 5

// Idle and start bit levels of the lines
`define SBR_PROG_IDLE 1'h1
`define SBR_START_BIT 1'h0

`endif

// ==== rtl/sbr_pkg.sv ====
// Types of the receive sample bridge: state encodings.
// Assumes sbr_regs.svh supplies the numeric constants.
`default_nettype none
package sbr_pkg;

  typedef enum logic [1:0] {SBR_RX_IDLE = 2'h1, SBR_RX_DATA = 2'h2} sbr_rx_type;
  typedef enum logic [1:0] {SBR_TX_IDLE = 2'h1, SBR_TX_SHIFT = 2'h2} sbr_tx_type;
  typedef enum logic [1:0] {SBR_PG_IDLE = 2'h1, SBR_PG_SHIFT = 2'h2} sbr_pg_type;

endpackage : sbr_pkg
`default_nettype wire

// ==== rtl/sbr_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to mclk; only stage two is read.
`timescale 1ns/100ps
`default_nettype none
module sbr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_level;

  // Next values of the two stages
  always_comb
  begin
    next_stage1 = pin;
    next_level = stage1;
  end

  // Stage registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      level <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      level <= next_level;
    end
  end

endmodule : sbr_sync
`default_nettype wire

// ==== rtl/sbr_bitclk.sv ====
// Fractional divider making the DSP bit clock from mclk.
// Assumes mclk at the rate in sbr_regs.svh; half periods are 4 or 5 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_bitclk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bit clock level and a pulse one cycle before its falling edge
  output logic bclk,
  output logic fall
);

  logic [`SBR_ACC_W-1:0] acc;
  logic [`SBR_ACC_W-1:0] next_acc;
  logic next_bclk;
  logic wrap;
  logic [`SBR_ACC_W-1:0] sum;

  // Phase accumulator toggles the clock twice per bit
  always_comb
  begin
    sum = acc + `SBR_ACC_W'(`SBR_ACC_STEP);
    wrap = (sum >= `SBR_ACC_W'(`SBR_MCLK_KHZ));
    next_acc = wrap ? sum - `SBR_ACC_W'(`SBR_MCLK_KHZ) : sum;
    next_bclk = wrap ? ~bclk : bclk;
    fall = wrap & bclk;
  end

  // Accumulator and clock registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc <= '0;
      bclk <= 1'h0;
    end
    else
    begin
      acc <= next_acc;
      bclk <= next_bclk;
    end
  end

endmodule : sbr_bitclk
`default_nettype wire

// ==== rtl/sbr_bridge.sv ====
// Receive sample bridge top: programs the back-end, deframes I/Q samples
// from the sampled back-end clock and data pair, and forwards them to the DSP.
// Assumes all link and host pins are asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_bridge
  import sbr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host general-purpose I/O
  input wire logic [`SBR_PROG_W-1:0] host_cfg_data,
  input wire logic host_cfg_strobe,
  output logic cfg_done,
  // Receiver back-end link
  input wire logic backend_clock,
  input wire logic sample_data,
  input wire logic sample_data_n,
  output logic backend_program_line,
  // DSP synchronous serial port
  output logic dsp_rx_data,
  output logic dsp_rx_bit_clock,
  output logic dsp_packet_interrupt
);

  logic [3:0] pins_s;
  logic [`SBR_PROG_W-1:0] cfg_s;
  logic bclk_s, dat_s, dat_n_s, stb_s;
  logic bclk_prev, stb_prev, next_bclk_prev, next_stb_prev;
  logic link_rise, stb_rise, bit_fall;

  // Pin synchronisers
  sbr_sync #(.WIDTH(4)) u_sync_ctl (
    .mclk(mclk),
    .rst(rst),
    .pin({backend_clock, sample_data, sample_data_n, host_cfg_strobe}),
    .level(pins_s)
  );
  sbr_sync #(.WIDTH(`SBR_PROG_W)) u_sync_cfg (
    .mclk(mclk),
    .rst(rst),
    .pin(host_cfg_data),
    .level(cfg_s)
  );
  assign {bclk_s, dat_s, dat_n_s, stb_s} = pins_s;

  // DSP bit clock generator
  sbr_bitclk u_bitclk (
    .mclk(mclk),
    .rst(rst),
    .bclk(dsp_rx_bit_clock),
    .fall(bit_fall)
  );

  // Edge detection on synchronised levels
  always_comb
  begin
    next_bclk_prev = bclk_s;
    next_stb_prev = stb_s;
    link_rise = bclk_s & ~bclk_prev;
    stb_rise = stb_s & ~stb_prev;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bclk_prev <= 1'h0;
      stb_prev <= 1'h0;
    end
    else
    begin
      bclk_prev <= next_bclk_prev;
      stb_prev <= next_stb_prev;
    end
  end

  // Program line sequencer: start bit, word MSB first, stop bit
  sbr_pg_type pg_state, next_pg_state;
  logic [`SBR_PROG_FRAME-1:0] pg_shift, next_pg_shift;
  logic [`SBR_PROG_CNT_W-1:0] pg_cnt, next_pg_cnt;
  logic [`SBR_PROG_TMR_W-1:0] pg_tmr, next_pg_tmr;
  logic next_prog_line, next_cfg_done;
  logic [`SBR_PROG_W-1:0] pg_word;

  always_comb
  begin
    pg_word = cfg_s;
    pg_word[`SBR_CLKSEL_BIT] = `SBR_CLKSEL_2M4;
    next_pg_state = pg_state;
    next_pg_shift = pg_shift;
    next_pg_cnt = pg_cnt;
    next_pg_tmr = pg_tmr;
    next_prog_line = backend_program_line;
    next_cfg_done = cfg_done;
    case (pg_state)
      SBR_PG_IDLE:
      begin
        next_prog_line = `SBR_PROG_IDLE;
        if (stb_rise)
        begin
          next_pg_state = SBR_PG_SHIFT;
          next_pg_shift = {`SBR_START_BIT, pg_word, `SBR_PROG_IDLE};
          next_pg_cnt = '0;
          next_pg_tmr = '0;
        end
      end
      SBR_PG_SHIFT:
      begin
        next_prog_line = pg_shift[`SBR_PROG_FRAME-1];
        if (pg_tmr == `SBR_PROG_TMR_W'(`SBR_PROG_BIT_CYC - 1))
        begin
          next_pg_tmr = '0;
          next_pg_shift = {pg_shift[`SBR_PROG_FRAME-2:0], `SBR_PROG_IDLE};
          next_pg_cnt = pg_cnt + `SBR_PROG_CNT_W'(1);
          if (pg_cnt == `SBR_PROG_CNT_W'(`SBR_PROG_FRAME - 1))
          begin
            next_pg_state = SBR_PG_IDLE;
            next_cfg_done = 1'h1;
          end
        end
        else
        begin
          next_pg_tmr = pg_tmr + `SBR_PROG_TMR_W'(1);
        end
      end
      default:
      begin
        next_pg_state = SBR_PG_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pg_state <= SBR_PG_IDLE;
      pg_shift <= '1;
      pg_cnt <= '0;
      pg_tmr <= '0;
      backend_program_line <= `SBR_PROG_IDLE;
      cfg_done <= 1'h0;
    end
    else
    begin
      pg_state <= next_pg_state;
      pg_shift <= next_pg_shift;
      pg_cnt <= next_pg_cnt;
      pg_tmr <= next_pg_tmr;
      backend_program_line <= next_prog_line;
      cfg_done <= next_cfg_done;
    end
  end

  // Link deframer: start bit then I and Q words, sampled on link rising edges
  sbr_rx_type rx_state, next_rx_state;
  logic [`SBR_PKT_W-1:0] rx_shift, next_rx_shift;
  logic [`SBR_PKT_CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic pkt_ready, next_pkt_ready, pair_ok;

  always_comb
  begin
    pair_ok = dat_s ^ dat_n_s;
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_cnt = rx_cnt;
    next_pkt_ready = 1'h0;
    case (rx_state)
      SBR_RX_IDLE:
      begin
        // Link rate is not trusted until the back-end is reprogrammed
        if (link_rise && cfg_done && pair_ok && dat_s == `SBR_START_BIT)
        begin
          next_rx_state = SBR_RX_DATA;
          next_rx_cnt = '0;
        end
      end
      SBR_RX_DATA:
      begin
        if (link_rise)
        begin
          if (!pair_ok)
          begin
            next_rx_state = SBR_RX_IDLE;
          end
          else
          begin
            next_rx_shift = {rx_shift[`SBR_PKT_W-2:0], dat_s};
            next_rx_cnt = rx_cnt + `SBR_PKT_CNT_W'(1);
            if (rx_cnt == `SBR_PKT_CNT_W'(`SBR_PKT_W - 1))
            begin
              next_rx_state = SBR_RX_IDLE;
              next_pkt_ready = 1'h1;
            end
          end
        end
      end
      default:
      begin
        next_rx_state = SBR_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_state <= SBR_RX_IDLE;
      rx_shift <= '0;
      rx_cnt <= '0;
      pkt_ready <= 1'h0;
    end
    else
    begin
      rx_state <= next_rx_state;
      rx_shift <= next_rx_shift;
      rx_cnt <= next_rx_cnt;
      pkt_ready <= next_pkt_ready;
    end
  end

  // DSP serial transmitter: I word then Q word, MSB first, changes on falling bit clock
  sbr_tx_type tx_state, next_tx_state;
  logic [`SBR_PKT_W-1:0] tx_hold, next_tx_hold, tx_shift, next_tx_shift;
  logic [`SBR_PKT_CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic tx_pend, next_tx_pend, next_rx_data, next_pkt_int;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_hold = pkt_ready ? rx_shift : tx_hold;
    next_tx_pend = tx_pend | pkt_ready;
    next_tx_shift = tx_shift;
    next_tx_cnt = tx_cnt;
    next_rx_data = dsp_rx_data;
    next_pkt_int = dsp_packet_interrupt;
    case (tx_state)
      SBR_TX_IDLE:
      begin
        if (bit_fall && tx_pend)
        begin
          next_tx_state = SBR_TX_SHIFT;
          next_tx_shift = {tx_hold[`SBR_PKT_W-2:0], 1'h0};
          next_rx_data = tx_hold[`SBR_PKT_W-1];
          next_pkt_int = 1'h1;
          next_tx_cnt = `SBR_PKT_CNT_W'(1);
          next_tx_pend = pkt_ready; // A packet landing now stays pending
        end
      end
      SBR_TX_SHIFT:
      begin
        if (bit_fall)
        begin
          next_pkt_int = 1'h0;
          if (tx_cnt == `SBR_PKT_CNT_W'(`SBR_PKT_W))
          begin
            next_tx_state = SBR_TX_IDLE;
            next_rx_data = 1'h0;
          end
          else
          begin
            next_rx_data = tx_shift[`SBR_PKT_W-1];
            next_tx_shift = {tx_shift[`SBR_PKT_W-2:0], 1'h0};
            next_tx_cnt = tx_cnt + `SBR_PKT_CNT_W'(1);
          end
        end
      end
      default:
      begin
        next_tx_state = SBR_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_state <= SBR_TX_IDLE;
      tx_hold <= '0;
      tx_pend <= 1'h0;
      tx_shift <= '0;
      tx_cnt <= '0;
      dsp_rx_data <= 1'h0;
      dsp_packet_interrupt <= 1'h0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_hold <= next_tx_hold;
      tx_pend <= next_tx_pend;
      tx_shift <= next_tx_shift;
      tx_cnt <= next_tx_cnt;
      dsp_rx_data <= next_rx_data;
      dsp_packet_interrupt <= next_pkt_int;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_prog_idle_high: assert property (pg_state == SBR_PG_IDLE ##1 pg_state == SBR_PG_IDLE
    |-> backend_program_line) else $error("program line not idle high");
  a_prog_clksel: assert property (stb_rise && pg_state == SBR_PG_IDLE
    |=> pg_shift[`SBR_PROG_FRAME-2-`SBR_PROG_W+1+`SBR_CLKSEL_BIT]) else $error("clock select not forced");
  a_prog_start: assert property ($rose(pg_state == SBR_PG_SHIFT)
    |=> !backend_program_line) else $error("start bit missing");
  a_rx_gated: assert property (!cfg_done |-> rx_state == SBR_RX_IDLE)
    else $error("link sampled before configuration");
  a_rx_bad_pair: assert property (rx_state == SBR_RX_DATA && link_rise && !pair_ok
    |=> rx_state == SBR_RX_IDLE && !pkt_ready) else $error("bad pair not dropped");
  a_bit_half: assert property ($rose(dsp_rx_bit_clock)
    |-> ##[4:5] $fell(dsp_rx_bit_clock)) else $error("bit clock half period wrong");
  a_data_sync: assert property ($changed(dsp_rx_data) |-> $fell(dsp_rx_bit_clock))
    else $error("data moved off falling bit clock");
  a_int_width: assert property ($rose(dsp_packet_interrupt)
    |-> ##[8:9] $fell(dsp_packet_interrupt)) else $error("packet interrupt not one bit");
  a_int_msb: assert property ($rose(dsp_packet_interrupt)
    |-> dsp_rx_data == $past(tx_hold[`SBR_PKT_W-1])) else $error("packet not MSB first");

  c_config: cover property ($rose(cfg_done));
  c_packet: cover property (pkt_ready);
  c_send: cover property ($fell(tx_state == SBR_TX_SHIFT));
  c_bad_pair: cover property (rx_state == SBR_RX_DATA && link_rise && !pair_ok);

endmodule : sbr_bridge
`default_nettype wire

// ==== bench/sbr_far_model.sv ====
// Far side of the bridge: back-end link sender and DSP serial receiver.
// Assumes a 10 MHz mclk; the link clock runs free, unrelated in phase.
`timescale 1ns/100ps
`default_nettype none
module sbr_far_model (
  // System clock
  input wire logic mclk,
  // Back-end link
  output logic backend_clock,
  output logic sample_data,
  output logic sample_data_n,
  input wire logic backend_program_line,
  // DSP serial port
  input wire logic dsp_rx_data,
  input wire logic dsp_rx_bit_clock,
  input wire logic dsp_packet_interrupt
);
  realtime half = 400;
  logic [17:0] prog_q[$];
  logic [31:0] pkt_q[$];
  int int_width = 0;
  int cnt = 0;
  // Link clock runs from power-up, idle line high
  initial
  begin
    backend_clock = 1'h0;
    sample_data = 1'h1;
    sample_data_n = 1'h0;
    #37;
    forever #(half) backend_clock = ~backend_clock;
  end
  // Start bit, I then Q MSB first; a bad bit makes both lines equal and ends the frame
  task automatic send_packet(input logic [31:0] iq, input int bad, input bit gap);
    logic [32:0] frame;
    frame = {1'h0, iq};
    for (int k = 32; k >= 0; k--)
    begin
      @(negedge backend_clock);
      sample_data = frame[k];
      sample_data_n = (32 - k == bad) ? frame[k] : ~frame[k];
      if (32 - k == bad)
        break;
    end
    if (gap || bad <= 32)
    begin
      @(negedge backend_clock);
      sample_data = 1'h1;
      sample_data_n = 1'h0;
    end
  endtask : send_packet
  // Program frames sampled mid-bit, 16 cycles a bit
  initial
  forever
  begin
    logic [17:0] f;
    @(negedge backend_program_line);
    repeat (8) @(posedge mclk);
    for (int k = 17; k >= 0; k--)
    begin
      f[k] = backend_program_line;
      if (k > 0)
        repeat (16) @(posedge mclk);
    end
    prog_q.push_back(f);
  end
  // DSP receive: 32 bits on rising bit clock after each packet interrupt
  initial
  forever
  begin
    logic [31:0] w;
    @(posedge dsp_packet_interrupt);
    for (int k = 31; k >= 0; k--)
    begin
      @(posedge dsp_rx_bit_clock);
      w[k] = dsp_rx_data;
    end
    pkt_q.push_back(w);
  end
  // Interrupt width in mclk cycles, read away from the launching edge
  always @(negedge mclk)
  begin
    if (dsp_packet_interrupt === 1'h1)
      cnt = cnt + 1;
    else if (cnt != 0)
    begin
      int_width = cnt;
      cnt = 0;
    end
  end
endmodule : sbr_far_model
`default_nettype wire

// ==== bench/sbr_bridge_tb_top.sv ====
// Self-checking bench of the receive sample bridge.
// Assumes sbr_far_model on the link and DSP sides; host pins driven here.
`timescale 1ns/100ps
`default_nettype none
`include "sbr_regs.svh"
module sbr_bridge_tb_top;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [`SBR_PROG_W-1:0] host_cfg_data = 16'h0;
  logic host_cfg_strobe = 1'h0;
  logic cfg_done, backend_clock, sample_data, sample_data_n, backend_program_line;
  logic dsp_rx_data, dsp_rx_bit_clock, dsp_packet_interrupt;
  int bad_count = 0;
  int checks_done = 0;
  realtime t0;
  logic [4:0] out_state;
  // Output levels gathered for the reset checks
  assign out_state = {cfg_done, backend_program_line, dsp_rx_data, dsp_rx_bit_clock,
    dsp_packet_interrupt};
  typedef struct {logic [15:0] cfg; logic [17:0] frame; logic [31:0] iq;} sbr_row_type;
  sbr_row_type rows [3] = '{'{16'h1234, 18'h0246b, 32'h8001_7ffe},
    '{16'hfffe, 18'h1ffff, 32'hffff_0000}, '{16'h8000, 18'h10003, 32'h0000_0001}};
  // Device and far side
  sbr_bridge i_sbr_bridge (.mclk, .rst, .host_cfg_data, .host_cfg_strobe, .cfg_done,
    .backend_clock, .sample_data, .sample_data_n, .backend_program_line, .dsp_rx_data,
    .dsp_rx_bit_clock, .dsp_packet_interrupt);
  sbr_far_model i_sbr_far_model (.mclk, .backend_clock, .sample_data, .sample_data_n,
    .backend_program_line, .dsp_rx_data, .dsp_rx_bit_clock, .dsp_packet_interrupt);
  // 10 MHz clock
  always #50 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Host word then a short strobe pulse
  task automatic host_write(input logic [15:0] w);
    host_cfg_data <= w;
    repeat (2) @(posedge mclk);
    host_cfg_strobe <= 1'h1;
    repeat (4) @(posedge mclk);
    host_cfg_strobe <= 1'h0;
  endtask : host_write
  // Bounded wait on a capture queue; a shortfall shows in the next compare
  task automatic wait_for(input bit prog, input int want);
    for (int k = 0; k < 2000; k++)
    begin
      @(posedge mclk);
      if ((prog ? i_sbr_far_model.prog_q.size() : i_sbr_far_model.pkt_q.size()) >= want)
        return;
    end
  endtask : wait_for
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    check(out_state, 5'h08);
    rst <= 1'h0;
    $display("reset test done");
    // Fast link before configuration carries nothing through
    i_sbr_far_model.half = 104;
    i_sbr_far_model.send_packet(32'h1234_5678, 40, 1'h1);
    i_sbr_far_model.half = 400;
    i_sbr_far_model.send_packet(32'h1234_5678, 40, 1'h1);
    repeat (400) @(posedge mclk);
    check(i_sbr_far_model.pkt_q.size(), 0);
    check(cfg_done, 0);
    $display("unconfigured test done");
    foreach (rows[r])
    begin
      host_write(rows[r].cfg);
      wait_for(1, r + 1);
      repeat (16) @(posedge mclk);
      check(i_sbr_far_model.prog_q[r], rows[r].frame);
      check(cfg_done, 1);
      i_sbr_far_model.send_packet(rows[r].iq, 40, 1'h1);
      wait_for(0, r + 1);
      check(i_sbr_far_model.pkt_q[r], rows[r].iq);
      check(32'(i_sbr_far_model.int_width inside {8, 9}), 1);
      $display("row %0d done", r);
    end
    // Strobe inside a frame is ignored
    host_write(16'h00f0);
    repeat (50) @(posedge mclk);
    host_write(16'h0f00);
    wait_for(1, 5);
    check(i_sbr_far_model.prog_q.size(), 4);
    check(i_sbr_far_model.prog_q[3], 18'h001e3);
    $display("refused strobe test done");
    // Equal true and complement lines drop the packet
    i_sbr_far_model.send_packet(32'hdead_beef, 10, 1'h1);
    i_sbr_far_model.send_packet(32'h0f0f_f0f0, 40, 1'h1);
    wait_for(0, 5);
    check(i_sbr_far_model.pkt_q.size(), 4);
    check(i_sbr_far_model.pkt_q[3], 32'h0f0f_f0f0);
    $display("bad pair test done");
    // Back to back packets, one interrupt each
    i_sbr_far_model.send_packet(32'h5a5a_a5a5, 40, 1'h0);
    i_sbr_far_model.send_packet(32'h0123_fedc, 40, 1'h1);
    wait_for(0, 6);
    check(i_sbr_far_model.pkt_q.size(), 6);
    check(i_sbr_far_model.pkt_q[4], 32'h5a5a_a5a5);
    check(i_sbr_far_model.pkt_q[5], 32'h0123_fedc);
    $display("back to back test done");
    // Twelve bit clock periods span 10 us
    @(posedge dsp_rx_bit_clock);
    t0 = $realtime;
    repeat (12) @(posedge dsp_rx_bit_clock);
    check(32'(($realtime - t0) >= 9900 && ($realtime - t0) <= 10100), 1);
    $display("bit clock test done");
    // Reset in mid-run clears the configuration and gates the link again
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    check(out_state, 5'h08);
    rst <= 1'h0;
    repeat (2) @(negedge mclk);
    check(out_state, 5'h08);
    i_sbr_far_model.send_packet(32'h2468_ace0, 40, 1'h1);
    repeat (300) @(posedge mclk);
    check(i_sbr_far_model.pkt_q.size(), 6);
    check(cfg_done, 0);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule : sbr_bridge_tb_top
`default_nettype wire
